// file: rtl/iflm_pkg.sv
// constants, field layout and carrier types of the input fault latch and mask block
// assumes one core clock, synchronous reset, fault detectors outside the block

package iflm_pkg;

   // ************************************************
   // register addresses
   // ************************************************
   localparam logic [7:0] IFLM_ADDR_CHAN1_LATCH = 8'h2e;
   localparam logic [7:0] IFLM_ADDR_CHAN2_LATCH = 8'h2f;
   localparam logic [7:0] IFLM_ADDR_MASK = 8'h34;
   localparam logic [7:0] IFLM_ADDR_OV_A = 8'h35;
   localparam logic [7:0] IFLM_ADDR_OV_B = 8'h36;

   // ************************************************
   // field layout and reset values
   // ************************************************
   localparam int unsigned IFLM_C2_OPEN = 7;
   localparam int unsigned IFLM_C2_PAIR = 6;
   localparam int unsigned IFLM_C2_POS_GND = 5;
   localparam int unsigned IFLM_C2_NEG_GND = 4;
   localparam int unsigned IFLM_C2_POS_BIAS = 3;
   localparam int unsigned IFLM_C2_NEG_BIAS = 2;
   localparam int unsigned IFLM_C2_POS_BAT = 1;
   localparam int unsigned IFLM_C2_NEG_BAT = 0;
   localparam int unsigned IFLM_MASK_OV_POS = 7;
   localparam int unsigned IFLM_MASK_OV_NEG = 6;
   localparam int unsigned IFLM_MASK_BIAS_HI = 5;
   localparam int unsigned IFLM_MASK_BIAS_LO = 4;
   localparam int unsigned IFLM_MASK_BIAS_OV = 3;
   localparam logic [7:0] IFLM_MASK_WR_BITS = 8'hf8;
   localparam int unsigned IFLM_OV_CH1 = 7;
   localparam int unsigned IFLM_OV_CH2 = 6;
   localparam logic [7:0] IFLM_OV_USED_BITS = 8'hc0;
   localparam logic [7:0] IFLM_RESET_VAL = 8'h00;

   // ************************************************
   // carriers
   // ************************************************
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } iflm_req_t;

   // ov_pos and ov_neg: index 1 is channel 1, index 0 is channel 2
   typedef struct packed {
      logic [7:0] chan2;
      logic [1:0] ov_pos;
      logic [1:0] ov_neg;
   } iflm_fault_t;

endpackage

// file: rtl/iflm_top.sv
// input fault latches, fault mask and interrupt request of the converter diagnostics
// assumes control port requests and detector pulses synchronous to core_clk
`timescale 1ns/10ps

module iflm_top
   import iflm_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input iflm_req_t req,
   input iflm_fault_t fault,
   output logic [7:0] rdata,
   output logic rvalid,
   output logic irq,
   output logic [2:0] bias_mask
);

   // ************************************************
   // decode
   // ************************************************
   function automatic logic rd_at(input iflm_req_t r, input logic [7:0] a);
      rd_at = r.rd && (r.addr == a);
   endfunction

   function automatic logic wr_at(input iflm_req_t r, input logic [7:0] a);
      wr_at = r.wr && (r.addr == a);
   endfunction

   // set wins over clear, so a fault in the cycle of its read is kept
   function automatic logic latch_step(input logic held, input logic clr, input logic set);
      latch_step = (held && !clr) || set;
   endfunction

   // a register requests while any latched bit is set and its mask is low
   function automatic logic pending(input logic [7:0] latched, input logic masked);
      pending = (|latched) && !masked;
   endfunction

   logic [7:0] chan2_fault_latch_reg;
   logic [7:0] fault_mask_three_reg;
   logic [7:0] overvoltage_latch_a_reg;
   logic [7:0] overvoltage_latch_b_reg;
   logic [7:0] chan2_set;
   logic [7:0] chan2_clr;
   logic [7:0] ov_a_set;
   logic [7:0] ov_b_set;
   logic [7:0] ov_clr;
   logic [7:0] mask_next;
   logic [7:0] read_sel;
   logic rd_chan1;
   logic rd_chan2;
   logic rd_ov_b;
   logic wr_mask;
   logic chan2_pending;
   logic ov_pos_pending;
   logic ov_neg_pending;
   logic irq_next;

   assign rd_chan1 = rd_at(req, IFLM_ADDR_CHAN1_LATCH);
   assign rd_chan2 = rd_at(req, IFLM_ADDR_CHAN2_LATCH);
   assign rd_ov_b = rd_at(req, IFLM_ADDR_OV_B);
   assign wr_mask = wr_at(req, IFLM_ADDR_MASK);

   // ************************************************
   // set and clear terms
   // ************************************************
   always_comb begin
      chan2_set = IFLM_RESET_VAL;
      chan2_set[IFLM_C2_OPEN] = fault.chan2[IFLM_C2_OPEN];
      chan2_set[IFLM_C2_PAIR] = fault.chan2[IFLM_C2_PAIR];
      chan2_set[IFLM_C2_POS_GND] = fault.chan2[IFLM_C2_POS_GND];
      chan2_set[IFLM_C2_NEG_GND] = fault.chan2[IFLM_C2_NEG_GND];
      chan2_set[IFLM_C2_POS_BIAS] = fault.chan2[IFLM_C2_POS_BIAS];
      chan2_set[IFLM_C2_NEG_BIAS] = fault.chan2[IFLM_C2_NEG_BIAS];
      chan2_set[IFLM_C2_POS_BAT] = fault.chan2[IFLM_C2_POS_BAT];
      chan2_set[IFLM_C2_NEG_BAT] = fault.chan2[IFLM_C2_NEG_BAT];
      // own read clears all but the battery-negative bit
      chan2_clr = {8{rd_chan2}};
      chan2_clr[IFLM_C2_NEG_BAT] = rd_ov_b;
   end

   always_comb begin
      ov_a_set = IFLM_RESET_VAL;
      ov_b_set = IFLM_RESET_VAL;
      ov_clr = IFLM_RESET_VAL;
      ov_a_set[IFLM_OV_CH1] = fault.ov_pos[1];
      ov_a_set[IFLM_OV_CH2] = fault.ov_pos[0];
      ov_b_set[IFLM_OV_CH1] = fault.ov_neg[1];
      ov_b_set[IFLM_OV_CH2] = fault.ov_neg[0];
      // overvoltage bits clear on the channel latch reads, not their own
      ov_clr[IFLM_OV_CH1] = rd_chan1;
      ov_clr[IFLM_OV_CH2] = rd_chan2;
   end

   // ************************************************
   // channel 2 latch
   // ************************************************
   for (genvar i = 0; i < $bits(chan2_fault_latch_reg); i++) begin : g_chan2
      always_ff @(posedge core_clk) begin
         if (rst) begin
            chan2_fault_latch_reg[i] <= IFLM_RESET_VAL[i];
         end else begin
            chan2_fault_latch_reg[i] <= latch_step(chan2_fault_latch_reg[i], chan2_clr[i],
               chan2_set[i]);
         end
      end
   end

   // ************************************************
   // overvoltage latches
   // ************************************************
   // reserved bits are gated to zero every cycle, so they never store
   for (genvar i = 0; i < $bits(overvoltage_latch_a_reg); i++) begin : g_ov_a
      always_ff @(posedge core_clk) begin
         if (rst) begin
            overvoltage_latch_a_reg[i] <= IFLM_RESET_VAL[i];
         end else begin
            overvoltage_latch_a_reg[i] <= latch_step(overvoltage_latch_a_reg[i], ov_clr[i],
               ov_a_set[i]) && IFLM_OV_USED_BITS[i];
         end
      end
   end

   for (genvar i = 0; i < $bits(overvoltage_latch_b_reg); i++) begin : g_ov_b
      always_ff @(posedge core_clk) begin
         if (rst) begin
            overvoltage_latch_b_reg[i] <= IFLM_RESET_VAL[i];
         end else begin
            overvoltage_latch_b_reg[i] <= latch_step(overvoltage_latch_b_reg[i], ov_clr[i],
               ov_b_set[i]) && IFLM_OV_USED_BITS[i];
         end
      end
   end

   // ************************************************
   // mask register
   // ************************************************
   // reserved low bits never store, so they read back as zero
   assign mask_next = req.wdata & IFLM_MASK_WR_BITS;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         fault_mask_three_reg <= IFLM_RESET_VAL;
      end else if (wr_mask) begin
         fault_mask_three_reg <= mask_next;
      end
   end

   // one cycle behind the mask register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         bias_mask <= IFLM_RESET_VAL[2:0];
      end else begin
         bias_mask <= {fault_mask_three_reg[IFLM_MASK_BIAS_HI],
                       fault_mask_three_reg[IFLM_MASK_BIAS_LO],
                       fault_mask_three_reg[IFLM_MASK_BIAS_OV]};
      end
   end

   // ************************************************
   // read port
   // ************************************************
   // unmapped addresses, the channel 1 latch among them, read as zero
   always_comb begin
      unique case (req.addr)
         IFLM_ADDR_CHAN2_LATCH: read_sel = chan2_fault_latch_reg;
         IFLM_ADDR_MASK: read_sel = fault_mask_three_reg;
         IFLM_ADDR_OV_A: read_sel = overvoltage_latch_a_reg;
         IFLM_ADDR_OV_B: read_sel = overvoltage_latch_b_reg;
         default: read_sel = IFLM_RESET_VAL;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rvalid <= 1'b0;
      end else begin
         rvalid <= req.rd;
      end
   end

   // read returns the value before this cycle's clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata <= IFLM_RESET_VAL;
      end else if (req.rd) begin
         rdata <= read_sel;
      end
   end

   // ************************************************
   // interrupt sources
   // ************************************************
   // channel 2 latches have no mask in this block and always request
   assign chan2_pending = |chan2_fault_latch_reg;
   assign ov_pos_pending = pending(overvoltage_latch_a_reg,
      fault_mask_three_reg[IFLM_MASK_OV_POS]);
   assign ov_neg_pending = pending(overvoltage_latch_b_reg,
      fault_mask_three_reg[IFLM_MASK_OV_NEG]);

   // ************************************************
   // interrupt request
   // ************************************************
   assign irq_next = chan2_pending | ov_pos_pending | ov_neg_pending;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_next;
      end
   end

endmodule

// file: verification/iflm_host.sv
// host model on the control port: one request per wr or rd call, none per idle call
// assumes each call starts at a falling edge of core_clk
`timescale 1ns/10ps
module iflm_host
   import iflm_pkg::*;
(
   input wire logic core_clk,
   output iflm_req_t req,
   input wire logic [7:0] rdata,
   input wire logic rvalid
);
   // *****
   // access tasks
   // *****
   initial req = '0;
   task automatic idle();
      req = '0;
      @(negedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      // reserved bits only ever written as zero
      req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d & IFLM_MASK_WR_BITS};
      @(negedge core_clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(negedge core_clk);
      d = rdata;
      v = rvalid;
   endtask
endmodule

// file: verification/iflm_props.sv
// assertions on the read port, latches and irq of iflm_top
// assumes one core clock and a synchronous active-high rst
`timescale 1ns/10ps
module iflm_props
   import iflm_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input iflm_req_t req,
   input iflm_fault_t fault,
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   input wire logic irq,
   input wire logic [2:0] bias_mask
);
   // *****
   // properties
   // *****
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   wire rc2 = req.rd && req.addr == IFLM_ADDR_CHAN2_LATCH;
   wire rob = req.rd && req.addr == IFLM_ADDR_OV_B;
   property p_ans; req.rd |=> rvalid; endproperty
   a_ans: assert property (p_ans) else $error("read not answered");
   property p_one; !req.rd |=> !rvalid; endproperty
   a_one: assert property (p_one) else $error("read answer held too long");
   property p_rst; $fell(rst) |-> !irq && !rvalid && bias_mask == 3'h0; endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared");
   property p_rsv; rvalid && $past(req.addr) == IFLM_ADDR_OV_A |-> rdata[5:0] == 6'h00;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   property p_mask; req.wr && req.addr == IFLM_ADDR_MASK ##1 req.rd && !req.wr
      && req.addr == IFLM_ADDR_MASK |=> rdata == ($past(req.wdata, 2) & 8'hf8); endproperty
   a_mask: assert property (p_mask) else $error("mask readback wrong");
   property p_irq; fault.chan2 != 8'h00 |=> ##1 irq; endproperty
   a_irq: assert property (p_irq) else $error("irq missing");
   property p_clr; rc2 && fault.chan2 == 8'h00 ##1 rc2 |=> rdata[7:1] == 7'h00;
   endproperty
   a_clr: assert property (p_clr) else $error("latch not cleared");
   property p_keep; rc2 && fault.chan2[6] ##1 rc2 |=> rdata[6]; endproperty
   a_keep: assert property (p_keep) else $error("fault lost");
   property p_b0; rob && !fault.chan2[0] ##1 rc2 |=> !rdata[0]; endproperty
   a_b0: assert property (p_b0) else $error("bit 0 not cleared");
   c_irq: cover property ($rose(irq));
   c_rd: cover property (rvalid && rdata != 8'h00);
   c_wr: cover property (req.wr);
endmodule

bind iflm_top iflm_props u_props (.core_clk(core_clk), .rst(rst), .req(req), .fault(fault),
   .rdata(rdata), .rvalid(rvalid), .irq(irq), .bias_mask(bias_mask));

// file: verification/input_fault_latch_mask_bench.sv
// self-checking bench: reset values, latching, clearing reads, masks, irq
// assumes iflm_host drives req and this module drives fault
`timescale 1ns/10ps
module input_fault_latch_mask_bench;
   import iflm_pkg::*;
   localparam logic [7:0] L2 = IFLM_ADDR_CHAN2_LATCH;
   localparam logic [7:0] LA = IFLM_ADDR_OV_A;
   localparam logic [7:0] LB = IFLM_ADDR_OV_B;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   iflm_req_t req;
   iflm_fault_t fault = '0;
   logic [7:0] rdata, b;
   logic rvalid, irq;
   logic [2:0] bias_mask;
   int bad_count = 0;
   int checks_done = 0;
   always #5 core_clk = ~core_clk;
   iflm_host host (.core_clk(core_clk), .req(req), .rdata(rdata), .rvalid(rvalid));
   iflm_top uut (.core_clk(core_clk), .rst(rst), .req(req), .fault(fault), .rdata(rdata),
      .rvalid(rvalid), .irq(irq), .bias_mask(bias_mask));
   // *****
   // checks
   // *****
   task automatic cmp(input string n, input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", n, e, g);
         bad_count++;
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic v;
      host.rd(a, d, v);
      cmp("rvalid", {7'h00, v}, 8'h01);
      cmp("rdata", d, e);
   endtask
   task automatic irqc(input logic e);
      cmp("irq", {7'h00, irq}, {7'h00, e});
   endtask
   task automatic end_of_test();
      if (bad_count == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // tests take a little over a hundred cycles
   initial begin
      repeat (5000) @(posedge core_clk);
      bad_count++;
      end_of_test();
   end
   initial begin
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      host.idle();
      irqc(1'b0);
      rdc(L2, 8'h00);
      rdc(IFLM_ADDR_MASK, 8'h00);
      rdc(LA, 8'h00);
      rdc(LB, 8'h00);
      for (int i = 0; i < 8; i++) begin
         b = 8'h01 << i;
         fault.chan2 = b;
         host.idle();
         fault = '0;
         host.idle();
         irqc(1'b1);
         rdc(L2, b);
         rdc(L2, b & 8'h01);
         rdc(LB, 8'h00);
         rdc(L2, 8'h00);
         host.idle();
         host.idle();
         irqc(1'b0);
         cmp("rvalid", {7'h00, rvalid}, 8'h00);
      end
      fault.ov_pos = 2'b11;
      fault.ov_neg = 2'b11;
      host.idle();
      fault = '0;
      rdc(LA, 8'hc0);
      rdc(LB, 8'hc0);
      rdc(IFLM_ADDR_CHAN1_LATCH, 8'h00);
      rdc(LA, 8'h40);
      rdc(LB, 8'h40);
      rdc(L2, 8'h00);
      rdc(LA, 8'h00);
      rdc(LB, 8'h00);
      rdc(8'h00, 8'h00);
      host.wr(IFLM_ADDR_MASK, 8'hff);
      rdc(IFLM_ADDR_MASK, 8'hf8);
      cmp("bias_mask", {5'h00, bias_mask}, 8'h07);
      fault.ov_pos = 2'b01;
      host.idle();
      fault = '0;
      host.idle();
      host.idle();
      irqc(1'b0);
      host.wr(IFLM_ADDR_MASK, 8'h40);
      host.idle();
      irqc(1'b1);
      host.wr(IFLM_ADDR_MASK, 8'h00);
      rdc(L2, 8'h00);
      fault.ov_neg = 2'b10;
      host.wr(IFLM_ADDR_MASK, 8'h68);
      fault = '0;
      host.idle();
      host.idle();
      irqc(1'b0);
      cmp("bias_mask", {5'h00, bias_mask}, 8'h05);
      rdc(LB, 8'h80);
      host.wr(IFLM_ADDR_MASK, 8'h80);
      host.idle();
      irqc(1'b1);
      cmp("bias_mask", {5'h00, bias_mask}, 8'h00);
      rdc(IFLM_ADDR_CHAN1_LATCH, 8'h00);
      host.idle();
      irqc(1'b0);
      fault.chan2 = 8'h40;
      host.idle();
      rdc(L2, 8'h40);
      fault = '0;
      rdc(L2, 8'h40);
      rdc(L2, 8'h00);
      end_of_test();
   end
endmodule
